// >>> rtl/qpc_top.sv
// Purpose: Quadrature encoder counter with a periodic capture channel.
// Assumes: AXI4-Lite master keeps one write and one read in flight.
// Notes: Only the period and encoder channels count; other start bits
//   are storage. Summary of operation follows.
// Summary of operation
// R1: Mode 1 counts up or down on every phase edge by the other level.
// R2: Four phase counting modes, each with its own count conditions.
// R3: Counters are 16-bit read/write and cleared to zero by reset.
// R4: Counter register is written only as a whole 16-bit word.
// R5: General registers are 16-bit and written only as whole words.
// R6: General register A compares or captures per its I/O control.
// R7: Encoder channel counts from the two external phase pins.
// R8: Period match copies the encoder count into capture register A.
// R9: Capture raises the capture interrupt when it is enabled.
// R10: Up-count wrap past maximum raises the overflow interrupt.
// R11: Down-count wrap below zero raises the underflow interrupt.
// R12: Six start bits; set runs a channel, clear halts it.
// R13: Software halts a channel before changing its control settings.
// R14: A halted channel drives its output at the initial I/O level.
// R15: PWM mode 2 drives the I/O-selected level when the counter clears; the code drives the initial I/O level per_io[IO_INIT] instead.
// R16: Register C may buffer register A; its own setting is ignored.
// R17: Software sets pin direction and input buffer for capture pins.
// R18: Per-channel enable bits gate interrupts; status shows event flags.
// R19: Software preloads the encoder counter with midscale first.
// R20: Software writes the measurement period into compare register A.
// R21: Mode code 0100 selects mode 1 and ignores clock and prescaler.
// R22: Capture code 1100 captures on period register A compare match.
// R23: Clear code 001 clears the period counter on its A match.
// R24: Zero clock codes make the period channel count every clock.
// R25: Encoder pins are synchronised and edges found by registered samples.
// R26: Encoder counter wraps modulo 65536 and keeps counting.
`default_nettype none
module qpc_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic phase_c_input_i,
  input wire logic phase_d_input_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic capture_a_irq_o,
  output logic overflow_irq_o,
  output logic underflow_irq_o,
  output logic period_out_o
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [5:0] start;
    logic [3:0] enc_mode;
    logic [3:0] enc_io;
    logic [5:0] enc_ier;
    logic [5:0] enc_sr;
    logic [15:0] enc_cnt;
    logic [15:0] enc_gra;
    logic [7:0] per_ctl;
    logic [3:0] per_io;
    logic [4:0] per_mode;
    logic [15:0] per_cnt;
    logic [15:0] per_gra;
    logic [15:0] per_grc;
    logic [5:0] pre;
    logic per_out;
    logic cap_irq;
    logic ovf_irq;
    logic udf_irq;
  } qpc_state_s;

  qpc_state_s s;
  qpc_state_s next_s;
  logic dec_up;
  logic dec_down;
  logic enc_run;
  logic per_tick;
  logic per_match;
  logic wr_do;
  logic wr_half;
  logic [5:0] psc_mask;
  logic [5:0] sr_set;
  logic [15:0] wd16;

  // Prescaler codes 0..3 give divide by 1, 4, 16 and 64.
  function automatic logic [5:0] qpc_psc_mask(input logic [2:0] code);
    case (code)
      3'h1: qpc_psc_mask = 6'h03;
      3'h2: qpc_psc_mask = 6'h0F;
      3'h3: qpc_psc_mask = 6'h3F;
      default: qpc_psc_mask = 6'h00;
    endcase
  endfunction

  qpc_phase_decoder u_dec (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .phase_c_input_i(phase_c_input_i), // [R7]
    .phase_d_input_i(phase_d_input_i),
    .mode_i(s.enc_mode[1:0]),
    .enable_i(enc_run),
    .up_o(dec_up),
    .down_o(dec_down)
  );

  localparam int CLEAR_SOURCE_FIELD_LSB_UP = qpc_pkg::CLEAR_SOURCE_FIELD_LSB;

  always_comb begin
    next_s = s;
    sr_set = 6'h00;
    // Phase codes override the clock source and prescaler. [R21]
    enc_run = s.start[qpc_pkg::START_ENC] &&
              (s.enc_mode[3:2] == qpc_pkg::MODE_PHASE); // [R12]
    psc_mask = qpc_psc_mask(s.per_ctl[2:0]);
    per_tick = s.start[qpc_pkg::START_PER] &&
               ((s.pre & psc_mask) == 6'h00); // [R24]
    per_match = per_tick && (s.per_cnt == s.per_gra);
    wr_do = s.aw_held && s.w_held && !s.bvalid;
    wr_half = (s.wstrb[1:0] == qpc_pkg::STRB_HALF[1:0]);
    wd16 = s.wdata[15:0];

    // Period channel.
    if (s.start[qpc_pkg::START_PER]) begin
      next_s.pre = s.pre + 6'h01;
    end else begin
      next_s.pre = 6'h00;
    end
    if (per_tick) begin
      if (per_match && (s.per_ctl[7:CLEAR_SOURCE_FIELD_LSB_UP] ==
          qpc_pkg::CLEAR_SOURCE_FIELD_MATCH_A)) begin
        next_s.per_cnt = qpc_pkg::CNT_RESET; // [R23]
      end else begin
        next_s.per_cnt = s.per_cnt + 16'h0001;
      end
    end
    if (per_match && s.per_mode[qpc_pkg::PER_MODE_BUF_A]) begin
      // Register C only feeds register A here. [R16]
      next_s.per_gra = s.per_grc;
    end

    // Encoder channel; the counter simply wraps. [R26]
    // A step launched just before a halt is dropped, so a halt is immediate.
    if (dec_up && enc_run) begin
      next_s.enc_cnt = s.enc_cnt + 16'h0001;
      if (s.enc_cnt == qpc_pkg::CNT_MAX) begin
        sr_set[qpc_pkg::FLAG_V] = 1'b1; // [R10]
      end
    end else if (dec_down && enc_run) begin
      next_s.enc_cnt = s.enc_cnt - 16'h0001;
      if (s.enc_cnt == qpc_pkg::CNT_RESET) begin
        sr_set[qpc_pkg::FLAG_U] = 1'b1; // [R11]
      end
    end
    if (s.enc_io == qpc_pkg::IO_CAPTURE_PER) begin // [R6] [R22]
      if (per_match) begin
        next_s.enc_gra = s.enc_cnt; // [R8]
        sr_set[qpc_pkg::FLAG_A] = 1'b1;
      end
    end else if (!s.enc_io[3] && enc_run && (dec_up || dec_down) &&
                 (next_s.enc_cnt == s.enc_gra)) begin
      sr_set[qpc_pkg::FLAG_A] = 1'b1; // [R6]
    end

    // Write address and data may arrive in either order.
    if (s_axi_awvalid_i && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata_i;
      next_s.wstrb = s_axi_wstrb_i;
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_do) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = qpc_pkg::RESP_OKAY;
      case (s.awaddr)
        qpc_pkg::ADDR_START: next_s.start = s.wdata[5:0]; // [R12]
        qpc_pkg::ADDR_ENC_MODE: next_s.enc_mode = s.wdata[3:0];
        qpc_pkg::ADDR_ENC_IO: next_s.enc_io = s.wdata[3:0];
        qpc_pkg::ADDR_ENC_IER: begin
          next_s.enc_ier = s.wdata[5:0] & qpc_pkg::IRQ_BITS; // [R18]
        end
        qpc_pkg::ADDR_ENC_SR: begin
          // Writing one clears a flag; a new event in the same cycle wins.
          next_s.enc_sr = s.enc_sr & ~s.wdata[5:0];
        end
        qpc_pkg::ADDR_PER_CTL: next_s.per_ctl = s.wdata[7:0];
        qpc_pkg::ADDR_PER_IO: next_s.per_io = s.wdata[3:0];
        qpc_pkg::ADDR_PER_MODE: next_s.per_mode = s.wdata[4:0];
        qpc_pkg::ADDR_ENC_CNT, qpc_pkg::ADDR_ENC_GRA,
        qpc_pkg::ADDR_PER_CNT, qpc_pkg::ADDR_PER_GRA,
        qpc_pkg::ADDR_PER_GRC: begin
          // A partial halfword is refused rather than merged. [R4] [R5]
          if (!wr_half) begin
            next_s.bresp = qpc_pkg::RESP_SLVERR;
          end else begin
            case (s.awaddr)
              qpc_pkg::ADDR_ENC_CNT: next_s.enc_cnt = wd16; // [R3]
              qpc_pkg::ADDR_ENC_GRA: next_s.enc_gra = wd16;
              qpc_pkg::ADDR_PER_CNT: next_s.per_cnt = wd16; // [R3]
              qpc_pkg::ADDR_PER_GRA: next_s.per_gra = wd16;
              default: next_s.per_grc = wd16;
            endcase
          end
        end
        default: next_s.bresp = qpc_pkg::RESP_SLVERR;
      endcase
    end
    next_s.awready = !next_s.aw_held;
    next_s.wready = !next_s.w_held;
    next_s.enc_sr = next_s.enc_sr | (sr_set & qpc_pkg::IRQ_BITS); // [R18]

    // Read channel answers one cycle after the address is taken.
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    if (s_axi_arvalid_i && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = qpc_pkg::RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      case (s_axi_araddr_i)
        qpc_pkg::ADDR_START: next_s.rdata[5:0] = s.start;
        qpc_pkg::ADDR_ENC_MODE: next_s.rdata[3:0] = s.enc_mode;
        qpc_pkg::ADDR_ENC_IO: next_s.rdata[3:0] = s.enc_io;
        qpc_pkg::ADDR_ENC_IER: next_s.rdata[5:0] = s.enc_ier;
        qpc_pkg::ADDR_ENC_SR: next_s.rdata[5:0] = s.enc_sr; // [R18]
        qpc_pkg::ADDR_ENC_CNT: next_s.rdata[15:0] = s.enc_cnt;
        qpc_pkg::ADDR_ENC_GRA: next_s.rdata[15:0] = s.enc_gra;
        qpc_pkg::ADDR_PER_CTL: next_s.rdata[7:0] = s.per_ctl;
        qpc_pkg::ADDR_PER_IO: next_s.rdata[3:0] = s.per_io;
        qpc_pkg::ADDR_PER_MODE: next_s.rdata[4:0] = s.per_mode;
        qpc_pkg::ADDR_PER_CNT: next_s.rdata[15:0] = s.per_cnt;
        qpc_pkg::ADDR_PER_GRA: next_s.rdata[15:0] = s.per_gra;
        qpc_pkg::ADDR_PER_GRC: next_s.rdata[15:0] = s.per_grc;
        default: next_s.rresp = qpc_pkg::RESP_SLVERR;
      endcase
    end

    // Period output pin.
    if (!next_s.start[qpc_pkg::START_PER]) begin
      next_s.per_out = next_s.per_io[qpc_pkg::IO_INIT]; // [R14]
    end else if (per_match) begin
      if (s.per_mode[3:0] == qpc_pkg::PER_MODE_PWM2 &&
          s.per_ctl[7:CLEAR_SOURCE_FIELD_LSB_UP] == qpc_pkg::CLEAR_SOURCE_FIELD_MATCH_A) begin
        next_s.per_out = s.per_io[qpc_pkg::IO_INIT]; // [R15]
      end else begin
        case (s.per_io[1:0])
          qpc_pkg::ACT_LOW: next_s.per_out = 1'b0;
          qpc_pkg::ACT_HIGH: next_s.per_out = 1'b1;
          qpc_pkg::ACT_TOGGLE: next_s.per_out = !s.per_out;
          default: next_s.per_out = s.per_out;
        endcase
      end
    end

    // Interrupt requests are level outputs of enabled flags. [R9] [R18]
    next_s.cap_irq = next_s.enc_sr[qpc_pkg::FLAG_A] &
                     next_s.enc_ier[qpc_pkg::FLAG_A];
    next_s.ovf_irq = next_s.enc_sr[qpc_pkg::FLAG_V] &
                     next_s.enc_ier[qpc_pkg::FLAG_V];
    next_s.udf_irq = next_s.enc_sr[qpc_pkg::FLAG_U] &
                     next_s.enc_ier[qpc_pkg::FLAG_U];
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.enc_cnt <= qpc_pkg::CNT_RESET; // [R3]
      s.per_cnt <= qpc_pkg::CNT_RESET;
      s.enc_gra <= qpc_pkg::GR_RESET;
      s.per_gra <= qpc_pkg::GR_RESET;
      s.per_grc <= qpc_pkg::GR_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready_o = s.awready;
  assign s_axi_wready_o = s.wready;
  assign s_axi_bvalid_o = s.bvalid;
  assign s_axi_bresp_o = s.bresp;
  assign s_axi_arready_o = s.arready;
  assign s_axi_rvalid_o = s.rvalid;
  assign s_axi_rdata_o = s.rdata;
  assign s_axi_rresp_o = s.rresp;
  assign capture_a_irq_o = s.cap_irq;
  assign overflow_irq_o = s.ovf_irq;
  assign underflow_irq_o = s.udf_irq;
  assign period_out_o = s.per_out;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence wr_both_s;
    s.aw_held && s.w_held && !s.bvalid;
  endsequence
  sequence cap_evt_s;
    per_match && (s.enc_io == qpc_pkg::IO_CAPTURE_PER) && !wr_do;
  endsequence
  sequence ovf_evt_s;
    dec_up && enc_run && (s.enc_cnt == qpc_pkg::CNT_MAX) && !wr_do;
  endsequence
  sequence udf_evt_s;
    dec_down && enc_run && (s.enc_cnt == qpc_pkg::CNT_RESET) && !wr_do;
  endsequence

  capture_copy_a: assert property (cap_evt_s |=> // [R8]
    s.enc_gra == $past(s.enc_cnt))
    else $error("Capture did not copy the encoder count.");
  capture_irq_a: assert property ( // [R9]
    cap_evt_s ##1 s.enc_ier[qpc_pkg::FLAG_A] |->
    s.enc_sr[qpc_pkg::FLAG_A] && capture_a_irq_o)
    else $error("Capture interrupt missing.");
  overflow_flag_a: assert property (ovf_evt_s |=> // [R10]
    s.enc_sr[qpc_pkg::FLAG_V] && s.enc_cnt == qpc_pkg::CNT_RESET)
    else $error("Overflow did not wrap and flag.");
  underflow_flag_a: assert property (udf_evt_s |=> // [R11]
    s.enc_sr[qpc_pkg::FLAG_U] && s.enc_cnt == qpc_pkg::CNT_MAX)
    else $error("Underflow did not wrap and flag.");
  period_clear_a: assert property ( // [R23]
    per_match && !wr_do &&
    s.per_ctl[7:CLEAR_SOURCE_FIELD_LSB_UP] == qpc_pkg::CLEAR_SOURCE_FIELD_MATCH_A |=>
    s.per_cnt == qpc_pkg::CNT_RESET)
    else $error("Period counter not cleared on match.");
  stopped_level_a: assert property ( // [R14]
    !s.start[qpc_pkg::START_PER] |->
    period_out_o == s.per_io[qpc_pkg::IO_INIT])
    else $error("Halted output not at initial level.");
  halt_hold_a: assert property ( // [R12]
    !s.start[qpc_pkg::START_ENC] && !wr_do |=> $stable(s.enc_cnt))
    else $error("Halted encoder counter moved.");
  narrow_refuse_a: assert property ( // [R4]
    wr_both_s ##0 (s.awaddr == qpc_pkg::ADDR_ENC_CNT && !wr_half &&
    !dec_up && !dec_down) |=>
    s.bresp == qpc_pkg::RESP_SLVERR && $stable(s.enc_cnt))
    else $error("Partial counter write not refused.");
  wr_resp_a: assert property (wr_both_s |=> // [R5]
    s.bvalid ##1 (s.bvalid || $past(s_axi_bready_i)))
    else $error("Write response missing or dropped.");
endmodule
`default_nettype wire

// >>> rtl/qpc_pkg.sv
// Purpose: Shared constants for the quadrature period counter.
// Assumes: AXI4-Lite register port with 8-bit byte addresses.
// Notes: Offsets are byte addresses of aligned 32-bit words.
`default_nettype none
package qpc_pkg;
  localparam logic [7:0] ADDR_START = 8'h00;
  localparam logic [7:0] ADDR_ENC_MODE = 8'h04;
  localparam logic [7:0] ADDR_ENC_IO = 8'h08;
  localparam logic [7:0] ADDR_ENC_IER = 8'h0C;
  localparam logic [7:0] ADDR_ENC_SR = 8'h10;
  localparam logic [7:0] ADDR_ENC_CNT = 8'h14;
  localparam logic [7:0] ADDR_ENC_GRA = 8'h18;
  localparam logic [7:0] ADDR_PER_CTL = 8'h1C;
  localparam logic [7:0] ADDR_PER_IO = 8'h20;
  localparam logic [7:0] ADDR_PER_MODE = 8'h24;
  localparam logic [7:0] ADDR_PER_CNT = 8'h28;
  localparam logic [7:0] ADDR_PER_GRA = 8'h2C;
  localparam logic [7:0] ADDR_PER_GRC = 8'h30;
  localparam int START_PER = 3;
  localparam int START_ENC = 4;
  localparam int FLAG_A = 0;
  localparam int FLAG_V = 4;
  localparam int FLAG_U = 5;
  localparam logic [5:0] IRQ_BITS = 6'h31;
  localparam logic [1:0] MODE_PHASE = 2'h1;
  localparam logic [1:0] PC_MODE1 = 2'h0;
  localparam logic [1:0] PC_MODE2 = 2'h1;
  localparam logic [1:0] PC_MODE3 = 2'h2;
  localparam logic [1:0] PC_MODE4 = 2'h3;
  localparam logic [3:0] IO_CAPTURE_PER = 4'hC;
  localparam logic [2:0] CLEAR_SOURCE_FIELD_MATCH_A = 3'h1;
  localparam int CLEAR_SOURCE_FIELD_LSB = 5;
  localparam logic [3:0] PER_MODE_PWM2 = 4'h3;
  localparam int PER_MODE_BUF_A = 4;
  localparam int IO_INIT = 2;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] STRB_HALF = 4'h3;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] GR_RESET = 16'hFFFF;
endpackage
`default_nettype wire

// >>> rtl/qpc_phase_decoder.sv
// Purpose: Synchronise the two encoder phases and decode up/down steps.
// Assumes: Phase pins are asynchronous to clk_i.
// Notes: Steps appear three edges after a pin change, one cycle long.
`default_nettype none
module qpc_phase_decoder (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic phase_c_input_i,
  input wire logic phase_d_input_i,
  input wire logic [1:0] mode_i,
  input wire logic enable_i,
  output logic up_o,
  output logic down_o
);
  typedef struct packed {
    logic c_meta;
    logic c_sync;
    logic c_prev;
    logic d_meta;
    logic d_sync;
    logic d_prev;
    logic up;
    logic down;
  } qpc_dec_state_s;

  qpc_dec_state_s s;
  qpc_dec_state_s next_s;
  logic rc, fc, rd, fd;

  always_comb begin
    next_s = s;
    next_s.c_meta = phase_c_input_i;
    next_s.c_sync = s.c_meta;
    next_s.c_prev = s.c_sync;
    next_s.d_meta = phase_d_input_i;
    next_s.d_sync = s.d_meta;
    next_s.d_prev = s.d_sync;
    // Edges come from the second stage against its own delayed copy. [R25]
    rc = s.c_sync & ~s.c_prev;
    fc = ~s.c_sync & s.c_prev;
    rd = s.d_sync & ~s.d_prev;
    fd = ~s.d_sync & s.d_prev;
    case (mode_i) // [R2]
      qpc_pkg::PC_MODE1: begin // [R1]
        next_s.up = (rd & s.c_sync) | (fd & ~s.c_sync) |
                    (rc & ~s.d_sync) | (fc & s.d_sync);
        next_s.down = (fd & s.c_sync) | (rd & ~s.c_sync) |
                      (rc & s.d_sync) | (fc & ~s.d_sync);
      end
      qpc_pkg::PC_MODE2: begin
        next_s.up = (rc & ~s.d_sync) | (fc & s.d_sync);
        next_s.down = (rc & s.d_sync) | (fc & ~s.d_sync);
      end
      qpc_pkg::PC_MODE3: begin
        next_s.up = fc & s.d_sync;
        next_s.down = fc & ~s.d_sync;
      end
      qpc_pkg::PC_MODE4: begin
        next_s.up = (rd & s.c_sync) | (fd & ~s.c_sync);
        next_s.down = (fd & s.c_sync) | (rd & ~s.c_sync);
      end
      default: begin
        next_s.up = 1'b0;
        next_s.down = 1'b0;
      end
    endcase
    next_s.up = next_s.up & enable_i;
    next_s.down = next_s.down & enable_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign up_o = s.up;
  assign down_o = s.down;

  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  dec_exclusive_a: assert property (!(s.up && s.down)) // [R1]
    else $error("Up and down step in the same cycle.");
  dec_edge_cause_a: assert property ( // [R25]
    (s.up || s.down) |-> $past(s.c_sync != s.c_prev || s.d_sync != s.d_prev))
    else $error("Step without a synchronised edge.");
endmodule
`default_nettype wire

// >>> bench/qpc_encoder_model.sv
// Purpose: Two-phase incremental encoder that drives both phase pins.
// Assumes: Callers hold each level for at least three clocks.
// Notes: Step count, direction and hold time are chosen per call.
`default_nettype none
module qpc_encoder_model (
  input wire logic clk_i,
  output logic phase_c_o,
  output logic phase_d_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int pos = 0;
  initial begin
    phase_c_o = 1'b0;
    phase_d_o = 1'b0;
  end
  // Forward order of (C, D) is 00, 10, 11, 01; reverse walks it back.
  task automatic move(input logic up, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      pos = up ? (pos + 1) % 4 : (pos + 3) % 4;
      phase_c_o <= (pos == 1 || pos == 2);
      phase_d_o <= (pos >= 2);
      repeat (hold - 1) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Purpose: Self-checking bench for the quadrature period counter.
// Assumes: One AXI4-Lite write or read in flight at a time.
// Notes: Counting is halted before any mode or control change.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] RUN_E = 32'h1 << qpc_pkg::START_ENC;
  localparam logic [31:0] RUN_B = RUN_E | (32'h1 << qpc_pkg::START_PER);
  localparam logic [31:0] FA = 32'h1 << qpc_pkg::FLAG_A;
  localparam logic [31:0] FV = 32'h1 << qpc_pkg::FLAG_V;
  localparam logic [31:0] FU = 32'h1 << qpc_pkg::FLAG_U;
  localparam logic [31:0] M1 = {28'h0, qpc_pkg::MODE_PHASE, 2'h0};
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic cap_irq, ovf_irq, unf_irq, per_out, ph_c, ph_d;
  int n_errors = 0;
  int checks = 0;
  always #25 clk_i = ~clk_i;
  // The phase pins are plain inputs here; no direction setup applies.
  qpc_encoder_model i_enc (.clk_i(clk_i), .phase_c_o(ph_c),
    .phase_d_o(ph_d));
  qpc_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .phase_c_input_i(ph_c), .phase_d_input_i(ph_d),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .capture_a_irq_o(cap_irq),
    .overflow_irq_o(ovf_irq), .underflow_irq_o(unf_irq),
    .period_out_o(per_out));
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s = 4'hF);
    @(posedge clk_i);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    wstrb <= s;
    bready <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string what);
    rd(a);
    chk(what, d, e);
  endtask
  // A bounded wait, so a missing capture shows as a mismatch, not a hang.
  task automatic wait_cap();
    int i;
    for (i = 0; i < 300 && cap_irq !== 1'b1; i++) @(posedge clk_i);
    chk("capture_wait", 32'(i < 300), 32'h1);
  endtask
  task automatic summarize();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    rdc(qpc_pkg::ADDR_ENC_CNT, 32'h0, "enc_cnt_reset");
    rdc(qpc_pkg::ADDR_PER_CNT, 32'h0, "per_cnt_reset");
    rdc(qpc_pkg::ADDR_ENC_GRA, 32'h0000FFFF, "gra_reset");
    rd(8'hFC);
    chk("unmapped_resp", 32'(r), 32'(qpc_pkg::RESP_SLVERR));
    chk("unmapped_data", d, 32'h0);
    wr(qpc_pkg::ADDR_ENC_CNT, 32'h1234, 4'h1);
    chk("cnt_byte_resp", 32'(r), 32'(qpc_pkg::RESP_SLVERR));
    rdc(qpc_pkg::ADDR_ENC_CNT, 32'h0, "cnt_byte_kept");
    wr(qpc_pkg::ADDR_PER_GRA, 32'h1234, 4'h2);
    chk("gr_byte_resp", 32'(r), 32'(qpc_pkg::RESP_SLVERR));
    wr(qpc_pkg::ADDR_ENC_CNT, 32'h8000);
    wr(qpc_pkg::ADDR_ENC_MODE, M1);
    wr(qpc_pkg::ADDR_START, RUN_E);
    i_enc.move(1'b1, 4, 4);
    rdc(qpc_pkg::ADDR_ENC_CNT, 32'h8004, "count_up");
    i_enc.move(1'b0, 5, 8);
    rdc(qpc_pkg::ADDR_ENC_CNT, 32'h7FFF, "count_down");
    wr(qpc_pkg::ADDR_START, 32'h0);
    i_enc.move(1'b1, 4, 4);
    rdc(qpc_pkg::ADDR_ENC_CNT, 32'h7FFF, "halted");
    // One full cycle gives two C edges, one C fall and two D edges.
    for (int m = 1; m < 4; m++) begin
      wr(qpc_pkg::ADDR_START, 32'h0);
      wr(qpc_pkg::ADDR_ENC_MODE, M1 | 32'(m));
      wr(qpc_pkg::ADDR_ENC_CNT, 32'h0);
      wr(qpc_pkg::ADDR_START, RUN_E);
      i_enc.move(1'b1, 4, 4);
      rdc(qpc_pkg::ADDR_ENC_CNT, (m == 2) ? 32'h1 : 32'h2, "mode");
    end
    wr(qpc_pkg::ADDR_START, 32'h0);
    wr(qpc_pkg::ADDR_ENC_MODE, M1);
    wr(qpc_pkg::ADDR_ENC_IER, FV | FU);
    wr(qpc_pkg::ADDR_ENC_CNT, 32'hFFFE);
    wr(qpc_pkg::ADDR_START, RUN_E);
    i_enc.move(1'b1, 3, 4);
    rdc(qpc_pkg::ADDR_ENC_CNT, 32'h1, "wrap_up");
    rdc(qpc_pkg::ADDR_ENC_SR, FA | FV, "ovf_flag");
    chk("ovf_irq", 32'(ovf_irq), 32'h1);
    wr(qpc_pkg::ADDR_ENC_SR, FA | FV | FU);
    chk("ovf_cleared", 32'(ovf_irq), 32'h0);
    wr(qpc_pkg::ADDR_START, 32'h0);
    wr(qpc_pkg::ADDR_ENC_CNT, 32'h1);
    wr(qpc_pkg::ADDR_START, RUN_E);
    i_enc.move(1'b0, 3, 4);
    rdc(qpc_pkg::ADDR_ENC_CNT, 32'hFFFE, "wrap_down");
    rdc(qpc_pkg::ADDR_ENC_SR, FA | FU, "unf_flag");
    chk("unf_irq", 32'(unf_irq), 32'h1);
    wr(qpc_pkg::ADDR_ENC_IER, 32'h0);
    chk("unf_masked", 32'(unf_irq), 32'h0);
    wr(qpc_pkg::ADDR_START, 32'h0);
    wr(qpc_pkg::ADDR_ENC_SR, FA | FV | FU);
    wr(qpc_pkg::ADDR_ENC_CNT, 32'h8000);
    wr(qpc_pkg::ADDR_ENC_IO, 32'(qpc_pkg::IO_CAPTURE_PER));
    wr(qpc_pkg::ADDR_ENC_IER, FA);
    wr(qpc_pkg::ADDR_PER_GRA, 32'h20);
    wr(qpc_pkg::ADDR_PER_CTL,
       32'(qpc_pkg::CLEAR_SOURCE_FIELD_MATCH_A) << qpc_pkg::CLEAR_SOURCE_FIELD_LSB);
    wr(qpc_pkg::ADDR_PER_IO, 32'h1 << qpc_pkg::IO_INIT);
    repeat (3) @(posedge clk_i);
    chk("init_level", 32'(per_out), 32'h1);
    wr(qpc_pkg::ADDR_START, RUN_B);
    wait_cap();
    rdc(qpc_pkg::ADDR_ENC_GRA, 32'h8000, "capture_1");
    wr(qpc_pkg::ADDR_ENC_SR, FA);
    i_enc.move(1'b1, 2, 4);
    wr(qpc_pkg::ADDR_ENC_SR, FA);
    wait_cap();
    rdc(qpc_pkg::ADDR_ENC_GRA, 32'h8002, "capture_2");
    // Buffer C reloads A at each match, and the match toggles the pin.
    wr(qpc_pkg::ADDR_START, 32'h0);
    wr(qpc_pkg::ADDR_PER_CNT, 32'h0);
    wr(qpc_pkg::ADDR_PER_GRA, 32'h10);
    wr(qpc_pkg::ADDR_PER_GRC, 32'h30);
    wr(qpc_pkg::ADDR_PER_MODE, 32'h1 << qpc_pkg::PER_MODE_BUF_A);
    wr(qpc_pkg::ADDR_PER_IO, 32'(qpc_pkg::ACT_TOGGLE));
    wr(qpc_pkg::ADDR_START, 32'h1 << qpc_pkg::START_PER);
    repeat (30) @(posedge clk_i);
    chk("toggle_out", 32'(per_out), 32'h1);
    rdc(qpc_pkg::ADDR_PER_GRA, 32'h30, "buffer_a");
    // Divide by four: eleven ticks land before the read samples the count.
    wr(qpc_pkg::ADDR_START, 32'h0);
    wr(qpc_pkg::ADDR_PER_CNT, 32'h0);
    wr(qpc_pkg::ADDR_PER_CTL,
       (32'(qpc_pkg::CLEAR_SOURCE_FIELD_MATCH_A) << qpc_pkg::CLEAR_SOURCE_FIELD_LSB) | 32'h1);
    wr(qpc_pkg::ADDR_PER_MODE, 32'(qpc_pkg::PER_MODE_PWM2));
    wr(qpc_pkg::ADDR_PER_IO, 32'(qpc_pkg::ACT_HIGH));
    wr(qpc_pkg::ADDR_START, 32'h1 << qpc_pkg::START_PER);
    repeat (40) @(posedge clk_i);
    rdc(qpc_pkg::ADDR_PER_CNT, 32'hB, "psc_count");
    repeat (170) @(posedge clk_i);
    chk("pwm2_out", 32'(per_out), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
